// file: design/imuscs_pkg.sv
// constants, offsets and timing for the imu system control and status block
// How it works
// - command trigger bits start their function, then clear themselves when finished
// - command bit 7 halts sensing, reloads saved control settings, reruns start-up
// - command bit 3 copies user settings into the nonvolatile copy
// - command bits 2,1,0 latch dac, restore calibration, correct bias
// - sleep bit 8 enters normal sleep until a wake event
// - sleep ends on chip-select fall, reset-pin fall, or power cycle
// - sleep field 0x01..0xff sleeps that many half seconds
// - fixed read-only sixteen-bit product code
// - two read-only lot code words form one 32-bit lot value
// - unit number in bits 13:0, bits 15:14 read zero
// - write counter increments on every flash update, manual or after 1:0
// - misc bit 11 runs checksum, mismatch sets diagnostic bit 6
// - checksum takes 20 ms then its trigger bit clears
// - misc bit 10 runs self-test, reports bits 15:10 and 5, clears
// - misc bit 8 applies self-test stimulus while one
// - misc bit 7 enables gyro acceleration compensation, bit 6 percussion alignment
// - misc bits 2:0 enable, polarity, line of data-ready; reset 0x0006
// - flags read one for error; a read returns then clears them
// - persisting alarm and overrange errors set their flag again at the next sample end
// - flag 0 shows low supply and clears itself when supply recovers
// - flag 3 set when a transfer's clock edges are not a multiple of 16
// - flags 9,8 alarms, 4 overrange, 2 flash failure; 7 and 1 unused
// - sixteen-bit registers, low byte even address, written one byte at a time
// - a flash backup takes 75 ms
package imuscs_pkg;
  // register byte addresses (low byte)
  localparam logic [6:0] ADDR_NVM_COUNT  = 7'h00;
  localparam logic [6:0] ADDR_MISC       = 7'h34;
  localparam logic [6:0] ADDR_SLEEP      = 7'h3a;
  localparam logic [6:0] ADDR_DIAG       = 7'h3c;
  localparam logic [6:0] ADDR_GLOBAL     = 7'h3e;
  localparam logic [6:0] ADDR_LOT_FIRST  = 7'h52;
  localparam logic [6:0] ADDR_LOT_SECOND = 7'h54;
  localparam logic [6:0] ADDR_PRODUCT    = 7'h56;
  localparam logic [6:0] ADDR_UNIT       = 7'h58;

  // reset values and writable masks
  localparam logic [15:0] MISC_RESET     = 16'h0006;
  localparam logic [15:0] MISC_WR_MASK   = 16'h0dc7;
  localparam logic [7:0]  GLOBAL_WR_MASK = 8'h8f;
  localparam logic [15:0] UNIT_MASK      = 16'h3fff;
  localparam logic [15:0] DIAG_MASK      = 16'hff7d;

  // field positions
  localparam int unsigned GC_SWRESET  = 7;
  localparam int unsigned GC_FLASH    = 3;
  localparam int unsigned GC_DAC      = 2;
  localparam int unsigned GC_CAL      = 1;
  localparam int unsigned GC_BIAS     = 0;
  localparam int unsigned MC_CHECKSUM = 11;
  localparam int unsigned MC_SELFTEST = 10;
  localparam int unsigned MC_STIM     = 8;
  localparam int unsigned MC_ACC_COMP = 7;
  localparam int unsigned MC_PERC     = 6;
  localparam int unsigned MC_DR_EN    = 2;
  localparam int unsigned MC_DR_POL   = 1;
  localparam int unsigned MC_DR_SEL   = 0;
  localparam int unsigned SC_NORMAL   = 0; // bit 8 lands at bit 0 of the high byte
  localparam int unsigned DG_SUPPLY   = 0;
  localparam int unsigned DG_FLASH    = 2;
  localparam int unsigned DG_SPI      = 3;
  localparam int unsigned DG_RANGE    = 4;
  localparam int unsigned DG_ST_ANY   = 5;
  localparam int unsigned DG_CHECKSUM = 6;
  localparam int unsigned DG_ALARM1   = 8;
  localparam int unsigned DG_ALARM2   = 9;
  localparam int unsigned DG_ST_LO    = 10;

  // timing at the 20 MHz system clock
  localparam int unsigned CLK_KHZ      = 20_000;
  localparam int unsigned FLASH_MS     = 75;
  localparam int unsigned CHECKSUM_MS  = 20;
  localparam int unsigned HALF_SEC_MS  = 500;
  localparam int unsigned DR_PULSE_US  = 40;
  localparam int unsigned FLASH_CYC    = FLASH_MS * CLK_KHZ;
  localparam int unsigned CHECKSUM_CYC = CHECKSUM_MS * CLK_KHZ;
  localparam int unsigned HALF_SEC_CYC = HALF_SEC_MS * CLK_KHZ;
  localparam int unsigned DR_PULSE_CYC = (DR_PULSE_US * CLK_KHZ) / 1000;
  localparam int unsigned STARTUP_CYC  = 1000;
  localparam int unsigned SELFTEST_CYC = 1000;

  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_STARTUP, SEQ_FLASH, SEQ_CAL, SEQ_BIAS,
    SEQ_CHECKSUM, SEQ_SELFTEST, SEQ_SLEEP
  } imuscs_seq_type;
endpackage

// file: design/imuscs_top.sv
// system control, command sequencing and status flags of the imu
`timescale 1ns/1ps
module imuscs_top #(
  parameter int unsigned FLASH_CYCLES    = imuscs_pkg::FLASH_CYC,
  parameter int unsigned CHECKSUM_CYCLES = imuscs_pkg::CHECKSUM_CYC,
  parameter int unsigned HALF_SEC_CYCLES = imuscs_pkg::HALF_SEC_CYC,
  parameter int unsigned STARTUP_CYCLES  = imuscs_pkg::STARTUP_CYC,
  parameter int unsigned SELFTEST_CYCLES = imuscs_pkg::SELFTEST_CYC,
  parameter logic [15:0] PRODUCT_CODE    = 16'h5a5a, // arbitrary value
  parameter logic [15:0] LOT_FIRST       = 16'h1111, // arbitrary value
  parameter logic [15:0] LOT_SECOND      = 16'h2222, // arbitrary value
  parameter logic [15:0] UNIT_NUMBER     = 16'h0001  // arbitrary value
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        wr_en_in,
  input  wire logic [6:0]  wr_addr_in,
  input  wire logic [7:0]  wr_byte_in,
  input  wire logic        rd_en_in,
  input  wire logic [6:0]  rd_addr_in,
  input  wire logic        xfer_end_in,
  input  wire logic [3:0]  xfer_edges_in,
  input  wire logic        sample_tick_in,
  input  wire logic        cs_n_in,
  input  wire logic        rst_pin_n_in,
  input  wire logic        supply_low_in,
  input  wire logic        alarm1_in,
  input  wire logic        alarm2_in,
  input  wire logic        overrange_in,
  input  wire logic        flash_fail_in,
  input  wire logic        checksum_bad_in,
  input  wire logic [5:0]  selftest_fail_in,
  output logic [15:0]      rd_data_out,
  output logic             sensing_halt_out,
  output logic             sleeping_out,
  output logic             dac_latch_out,
  output logic             cal_restore_out,
  output logic             bias_correct_out,
  output logic             selftest_stim_out,
  output logic             accel_comp_en_out,
  output logic             percussion_en_out,
  output logic             digital_line_first_out,
  output logic             digital_line_first_oe_n_out,
  output logic             digital_line_second_out,
  output logic             digital_line_second_oe_n_out
);
  import imuscs_pkg::*;

  logic [15:0]    misc_q;
  logic [15:0]    misc_nvm_q;
  logic [7:0]     glob_q;
  logic [15:0]    diag_q;
  logic [15:0]    nvm_count_q;
  logic           sleep_req_q;
  logic [7:0]     sleep_dur_q;
  imuscs_seq_type seq_q;
  logic [31:0]    tmr_q;
  logic [7:0]     half_left_q;
  logic           timed_q;
  logic [7:0]     clr_glob_q;
  logic [1:0]     clr_misc_q;
  logic [7:0]     flash_done_mask_q;
  logic           reload_q;
  logic           flash_err_q;
  logic           chk_done_q;
  logic           st_done_q;
  logic [2:0]     cs_sync_q;
  logic [2:0]     rp_sync_q;
  logic [1:0]     sup_sync_q;
  logic [9:0]     dr_cnt_q;
  logic           wake;
  logic           wr_lo;
  logic           wr_hi;

  // byte write decode: even address is the low byte
  function automatic logic hit(input logic [6:0] a, input logic [6:0] base);
    return a[6:1] == base[6:1];
  endfunction

  // merge one byte into a word under a writable mask
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic hi,
                                        input logic [7:0] b, input logic [15:0] m);
    logic [15:0] nw;
    nw = hi ? {b, cur[7:0]} : {cur[15:8], b};
    return (nw & m) | (cur & ~m);
  endfunction

  assign wr_lo = wr_en_in & ~wr_addr_in[0];
  assign wr_hi = wr_en_in & wr_addr_in[0];

  // pin inputs: two flops, third flop only for edge detection
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cs_sync_q  <= 3'b111;
      rp_sync_q  <= 3'b111;
      sup_sync_q <= 2'b00;
    end else begin
      cs_sync_q  <= {cs_sync_q[1:0], cs_n_in};
      rp_sync_q  <= {rp_sync_q[1:0], rst_pin_n_in};
      sup_sync_q <= {sup_sync_q[0], supply_low_in};
    end
  end

  assign wake = (cs_sync_q[2] & ~cs_sync_q[1]) | (rp_sync_q[2] & ~rp_sync_q[1]);

  // misc control: bus bytes, self-clearing test triggers, reload on restart
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      misc_q <= MISC_RESET;
    end else begin
      logic [15:0] nx;
      nx = misc_q;
      if (reload_q) begin
        nx = misc_nvm_q & ~(16'h0001 << MC_CHECKSUM) & ~(16'h0001 << MC_SELFTEST);
      end
      if (clr_misc_q[1]) begin
        nx[MC_CHECKSUM] = 1'b0;
      end
      if (clr_misc_q[0]) begin
        nx[MC_SELFTEST] = 1'b0;
      end
      // masked bytes; a new write wins over a clear
      if (wr_en_in && hit(wr_addr_in, ADDR_MISC)) begin
        nx = merge(nx, wr_addr_in[0], wr_byte_in, MISC_WR_MASK);
      end
      misc_q <= nx;
    end
  end

  // global command: write one starts, sequencer clears when done
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      glob_q <= 8'h00;
    end else begin
      if (wr_lo && hit(wr_addr_in, ADDR_GLOBAL)) begin
        glob_q <= (glob_q & ~clr_glob_q) | (wr_byte_in & GLOBAL_WR_MASK);
      end else begin
        glob_q <= glob_q & ~clr_glob_q;
      end
    end
  end

  // sleep control is write-only; a write of bit 8 or of a nonzero duration posts a request
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sleep_req_q <= 1'b0;
      sleep_dur_q <= 8'h00;
    end else if (wr_en_in && hit(wr_addr_in, ADDR_SLEEP) &&
                 (wr_hi ? wr_byte_in[SC_NORMAL] : (wr_byte_in != 8'h00))) begin
      sleep_req_q <= 1'b1;
      sleep_dur_q <= wr_hi ? 8'h00 : wr_byte_in;
    end else if (seq_q == SEQ_SLEEP) begin
      sleep_req_q <= 1'b0;
    end
  end

  // function sequencer, one long job at a time
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      seq_q             <= SEQ_IDLE;
      tmr_q             <= 32'h0000_0000;
      half_left_q       <= 8'h00;
      timed_q           <= 1'b0;
      clr_glob_q        <= 8'h00;
      clr_misc_q        <= 2'b00;
      flash_done_mask_q <= 8'h00;
      reload_q          <= 1'b0;
      flash_err_q       <= 1'b0;
      chk_done_q        <= 1'b0;
      st_done_q         <= 1'b0;
      dac_latch_out     <= 1'b0;
      cal_restore_out   <= 1'b0;
      bias_correct_out  <= 1'b0;
      misc_nvm_q        <= MISC_RESET;
      nvm_count_q       <= 16'h0000;
    end else begin
      clr_glob_q       <= 8'h00;
      clr_misc_q       <= 2'b00;
      reload_q         <= 1'b0;
      flash_err_q      <= 1'b0;
      chk_done_q       <= 1'b0;
      st_done_q        <= 1'b0;
      dac_latch_out    <= 1'b0;
      cal_restore_out  <= 1'b0;
      bias_correct_out <= 1'b0;
      case (seq_q)
        SEQ_IDLE: begin
          tmr_q <= 32'h0000_0000;
          // skip while a clear mask is pending, so a finished command is not started twice
          if (glob_q[GC_SWRESET] && clr_glob_q == 8'h00) begin
            seq_q    <= SEQ_STARTUP;
            reload_q <= 1'b1;
          end else if (glob_q[GC_FLASH] && clr_glob_q == 8'h00) begin
            seq_q             <= SEQ_FLASH;
            flash_done_mask_q <= 8'h01 << GC_FLASH;
            misc_nvm_q        <= misc_q;
            nvm_count_q       <= nvm_count_q + 16'h0001;
          end else if (glob_q[GC_DAC] && clr_glob_q == 8'h00) begin
            dac_latch_out      <= 1'b1;
            clr_glob_q[GC_DAC] <= 1'b1;
          end else if (glob_q[GC_CAL] && clr_glob_q == 8'h00) begin
            seq_q           <= SEQ_CAL;
            cal_restore_out <= 1'b1;
          end else if (glob_q[GC_BIAS] && clr_glob_q == 8'h00) begin
            seq_q            <= SEQ_BIAS;
            bias_correct_out <= 1'b1;
          end else if (misc_q[MC_CHECKSUM] && clr_misc_q == 2'b00) begin
            seq_q <= SEQ_CHECKSUM;
          end else if (misc_q[MC_SELFTEST] && clr_misc_q == 2'b00) begin
            seq_q <= SEQ_SELFTEST;
          end else if (sleep_req_q) begin
            seq_q       <= SEQ_SLEEP;
            timed_q     <= sleep_dur_q != 8'h00;
            half_left_q <= sleep_dur_q;
          end
        end
        SEQ_STARTUP: begin
          tmr_q <= tmr_q + 32'h0000_0001;
          if (tmr_q >= STARTUP_CYCLES - 1) begin
            seq_q                  <= SEQ_IDLE;
            clr_glob_q[GC_SWRESET] <= 1'b1;
          end
        end
        SEQ_CAL, SEQ_BIAS: begin
          // automatic update after calibration or bias functions
          seq_q             <= SEQ_FLASH;
          tmr_q             <= 32'h0000_0000;
          flash_done_mask_q <= (seq_q == SEQ_CAL) ? (8'h01 << GC_CAL) : (8'h01 << GC_BIAS);
          misc_nvm_q        <= misc_q;
          nvm_count_q       <= nvm_count_q + 16'h0001;
        end
        SEQ_FLASH: begin
          tmr_q <= tmr_q + 32'h0000_0001;
          if (tmr_q >= FLASH_CYCLES - 1) begin
            seq_q       <= SEQ_IDLE;
            clr_glob_q  <= flash_done_mask_q;
            flash_err_q <= flash_fail_in;
          end
        end
        SEQ_CHECKSUM: begin
          tmr_q <= tmr_q + 32'h0000_0001;
          if (tmr_q >= CHECKSUM_CYCLES - 1) begin
            seq_q         <= SEQ_IDLE;
            clr_misc_q[1] <= 1'b1;
            chk_done_q    <= 1'b1;
          end
        end
        SEQ_SELFTEST: begin
          tmr_q <= tmr_q + 32'h0000_0001;
          if (tmr_q >= SELFTEST_CYCLES - 1) begin
            seq_q         <= SEQ_IDLE;
            clr_misc_q[0] <= 1'b1;
            st_done_q     <= 1'b1;
          end
        end
        SEQ_SLEEP: begin
          if (wake) begin
            seq_q <= SEQ_IDLE;
          end else if (timed_q) begin
            if (tmr_q >= HALF_SEC_CYCLES - 1) begin
              tmr_q       <= 32'h0000_0000;
              half_left_q <= half_left_q - 8'h01;
              if (half_left_q == 8'h01) begin
                seq_q <= SEQ_IDLE;
              end
            end else begin
              tmr_q <= tmr_q + 32'h0000_0001;
            end
          end
        end
        default: begin
          seq_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // diagnostic flags: sticky except supply flag 0, cleared by read, hardware set wins
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      diag_q <= 16'h0000;
    end else begin
      logic [15:0] nx;
      logic [15:0] set;
      nx  = diag_q;
      set = 16'h0000;
      if (rd_en_in && hit(rd_addr_in, ADDR_DIAG)) begin
        nx = 16'h0000;
      end
      // persisting conditions return at sample end
      if (sample_tick_in) begin
        set[DG_ALARM1] = alarm1_in;
        set[DG_ALARM2] = alarm2_in;
        set[DG_RANGE]  = overrange_in;
      end
      set[DG_SPI]      = xfer_end_in && (xfer_edges_in != 4'h0);
      set[DG_FLASH]    = flash_err_q;
      set[DG_CHECKSUM] = chk_done_q & checksum_bad_in;
      set[15:10]       = st_done_q ? selftest_fail_in : 6'b00_0000;
      set[DG_ST_ANY]   = st_done_q & (|selftest_fail_in);
      nx = (nx | set) & DIAG_MASK;
      // supply flag follows the supply level
      nx[DG_SUPPLY] = sup_sync_q[1];
      diag_q <= nx;
    end
  end

  // registered read data; unmapped and write-only addresses read zero
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= 16'h0000;
    end else if (rd_en_in) begin
      if (hit(rd_addr_in, ADDR_MISC)) begin
        rd_data_out <= misc_q;
      end else if (hit(rd_addr_in, ADDR_DIAG)) begin
        rd_data_out <= diag_q;
      end else if (hit(rd_addr_in, ADDR_GLOBAL)) begin
        rd_data_out <= {8'h00, glob_q};
      end else if (hit(rd_addr_in, ADDR_NVM_COUNT)) begin
        rd_data_out <= nvm_count_q;
      end else if (hit(rd_addr_in, ADDR_LOT_FIRST)) begin
        rd_data_out <= LOT_FIRST;
      end else if (hit(rd_addr_in, ADDR_LOT_SECOND)) begin
        rd_data_out <= LOT_SECOND;
      end else if (hit(rd_addr_in, ADDR_PRODUCT)) begin
        rd_data_out <= PRODUCT_CODE;
      end else if (hit(rd_addr_in, ADDR_UNIT)) begin
        rd_data_out <= UNIT_NUMBER & UNIT_MASK;
      end else begin
        rd_data_out <= 16'h0000;
      end
    end
  end

  // control outputs registered from the misc bits and sequencer state
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      selftest_stim_out <= 1'b0;
      accel_comp_en_out <= 1'b0;
      percussion_en_out <= 1'b0;
      sensing_halt_out  <= 1'b1;
      sleeping_out      <= 1'b0;
    end else begin
      selftest_stim_out <= misc_q[MC_STIM];
      accel_comp_en_out <= misc_q[MC_ACC_COMP];
      percussion_en_out <= misc_q[MC_PERC];
      sensing_halt_out  <= (seq_q == SEQ_STARTUP) || (seq_q == SEQ_SLEEP);
      sleeping_out      <= seq_q == SEQ_SLEEP;
    end
  end

  // data-ready pulse width counter, restarted by each sample tick
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      dr_cnt_q <= 10'h000;
    end else if (sample_tick_in) begin
      dr_cnt_q <= DR_PULSE_CYC[9:0];
    end else if (dr_cnt_q != 10'h000) begin
      dr_cnt_q <= dr_cnt_q - 10'h001;
    end
  end

  // data-ready drive; unselected line released (oe low drives the pin)
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      digital_line_first_out       <= 1'b0;
      digital_line_first_oe_n_out  <= 1'b1;
      digital_line_second_out      <= 1'b0;
      digital_line_second_oe_n_out <= 1'b1;
    end else begin
      digital_line_first_out       <= (dr_cnt_q != 10'h000) ~^ misc_q[MC_DR_POL];
      digital_line_second_out      <= (dr_cnt_q != 10'h000) ~^ misc_q[MC_DR_POL];
      digital_line_first_oe_n_out  <= ~(misc_q[MC_DR_EN] & ~misc_q[MC_DR_SEL]);
      digital_line_second_oe_n_out <= ~(misc_q[MC_DR_EN] & misc_q[MC_DR_SEL]);
    end
  end
endmodule

// file: bench/imuscs_top_sva.sv
// port assertions for the imu system control block
`timescale 1ns/1ps
module imuscs_top_sva
  import imuscs_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic        wr_en_in,
  input wire logic [6:0]  wr_addr_in,
  input wire logic [7:0]  wr_byte_in,
  input wire logic        rd_en_in,
  input wire logic [6:0]  rd_addr_in,
  input wire logic        xfer_end_in,
  input wire logic        sample_tick_in,
  input wire logic        cs_n_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        sensing_halt_out,
  input wire logic        sleeping_out,
  input wire logic        dac_latch_out,
  input wire logic        selftest_stim_out,
  input wire logic        digital_line_first_oe_n_out,
  input wire logic        digital_line_second_oe_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  property p_rd_hold; !rd_en_in |=> $stable(rd_data_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read word moved");
  property p_unit; rd_en_in && rd_addr_in[6:1] == ADDR_UNIT[6:1] |=> rd_data_out[15:14] == 2'b00;
  endproperty
  a_unit: assert property (p_unit) else $error("unit reserved bits set");
  // read clears flags; a gap with no transfer end or sample tick keeps bits 3, 4, 8 and 9 from re-setting
  property p_diag_clear;
    rd_en_in && rd_addr_in[6:1] == ADDR_DIAG[6:1] && !xfer_end_in && !sample_tick_in ##1
    !xfer_end_in && !sample_tick_in ##1 rd_en_in && rd_addr_in[6:1] == ADDR_DIAG[6:1]
    |=> (rd_data_out & 16'hfffe) == 16'h0000;
  endproperty
  a_diag_clear: assert property (p_diag_clear) else $error("flags survived read");
  property p_sleep_halt; sleeping_out |-> sensing_halt_out; endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("asleep but sensing");
  property p_wake; sleeping_out && $fell(cs_n_in) |-> ##[1:5] !sleeping_out; endproperty
  a_wake: assert property (p_wake) else $error("no wake on select");
  // dac latch is one pulse, launched by its command bit
  property p_dac_once; dac_latch_out |=> !dac_latch_out; endproperty
  a_dac_once: assert property (p_dac_once) else $error("dac pulse too long");
  property p_dac_cause;
    wr_en_in && wr_addr_in == ADDR_GLOBAL && wr_byte_in == 8'h04 && !sleeping_out
    |-> ##[1:300] dac_latch_out;
  endproperty
  a_dac_cause: assert property (p_dac_cause) else $error("dac latch missing");
  property p_stim; wr_en_in && wr_addr_in == 7'h35 && wr_byte_in[0] |-> ##[1:2] selftest_stim_out;
  endproperty
  a_stim: assert property (p_stim) else $error("stimulus not applied");
  property p_one_line; !digital_line_first_oe_n_out |-> digital_line_second_oe_n_out; endproperty
  a_one_line: assert property (p_one_line) else $error("both lines driven");
endmodule
bind imuscs_top imuscs_top_sva u_sva (.clk_sys_in, .reset_in, .wr_en_in, .wr_addr_in,
  .wr_byte_in, .rd_en_in, .rd_addr_in, .xfer_end_in, .sample_tick_in, .cs_n_in, .rd_data_out,
  .sensing_halt_out, .sleeping_out, .dac_latch_out, .selftest_stim_out,
  .digital_line_first_oe_n_out, .digital_line_second_oe_n_out);

// file: bench/imuscs_host.sv
// host model: byte writes, word reads and chip-select wake
`timescale 1ns/1ps
module imuscs_host (
  input  wire logic        clk_sys_in,
  input  wire logic [15:0] rd_data_in,
  output logic             wr_en_out,
  output logic [6:0]       wr_addr_out,
  output logic [7:0]       wr_byte_out,
  output logic             rd_en_out,
  output logic [6:0]       rd_addr_out,
  output logic             cs_n_out
);
  initial begin
    wr_en_out = 1'b0;
    wr_addr_out = 7'h7f;
    wr_byte_out = 8'h00;
    rd_en_out = 1'b0;
    rd_addr_out = 7'h7f;
    cs_n_out = 1'b1;
  end
  // one byte per strobe; released lines show the inverse, never stale data
  task automatic wr(input logic [6:0] a, input logic [7:0] b);
    @(posedge clk_sys_in);
    #1;
    wr_en_out = 1'b1;
    wr_addr_out = a;
    wr_byte_out = b;
    @(posedge clk_sys_in);
    #1;
    wr_en_out = 1'b0;
    wr_addr_out = ~a;
    wr_byte_out = ~b;
  endtask
  // word read, answer a cycle later
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    #1;
    rd_en_out = 1'b1;
    rd_addr_out = a;
    @(posedge clk_sys_in);
    #1;
    rd_en_out = 1'b0;
    rd_addr_out = ~a;
    d = rd_data_in;
  endtask
  // select pulse; a fall is a wake event
  task automatic wake();
    @(posedge clk_sys_in);
    #1;
    cs_n_out = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1;
    cs_n_out = 1'b1;
  endtask
endmodule

// file: bench/imuscs_top_tb.sv
// self-checking bench for the imu system control block
`timescale 1ns/1ps
module imuscs_top_tb;
  import imuscs_pkg::*;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, xfer_end = 1'b0, tick = 1'b0, sup_low = 1'b0;
  logic alarm1 = 1'b0, ck_bad = 1'b0, wr_en, rd_en, cs_n, halt, sleeping, stim, acc, perc;
  logic [3:0] edges = 4'h0;
  logic [5:0] st_fail = 6'h00;
  logic [6:0] wr_addr, rd_addr;
  logic [7:0] wr_byte;
  logic [15:0] rd_data, cnt;
  logic l1, l1_oe_n, l2, l2_oe_n, rp_n = 1'b1;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  imuscs_host host (.clk_sys_in, .rd_data_in(rd_data), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
    .wr_byte_out(wr_byte), .rd_en_out(rd_en), .rd_addr_out(rd_addr), .cs_n_out(cs_n));
  imuscs_top #(.FLASH_CYCLES(50), .CHECKSUM_CYCLES(40), .HALF_SEC_CYCLES(20),
    .UNIT_NUMBER(16'hc005)) dut (.clk_sys_in, .reset_in, .wr_en_in(wr_en), .wr_addr_in(wr_addr),
    .wr_byte_in(wr_byte), .rd_en_in(rd_en), .rd_addr_in(rd_addr), .xfer_end_in(xfer_end),
    .xfer_edges_in(edges), .sample_tick_in(tick), .cs_n_in(cs_n), .rst_pin_n_in(rp_n),
    .supply_low_in(sup_low), .alarm1_in(alarm1), .alarm2_in(alarm1), .overrange_in(alarm1),
    .flash_fail_in(ck_bad), .checksum_bad_in(ck_bad), .selftest_fail_in(st_fail),
    .rd_data_out(rd_data), .sensing_halt_out(halt), .sleeping_out(sleeping),
    .dac_latch_out(), .cal_restore_out(), .bias_correct_out(), .selftest_stim_out(stim),
    .accel_comp_en_out(acc), .percussion_en_out(perc), .digital_line_first_out(l1),
    .digital_line_first_oe_n_out(l1_oe_n), .digital_line_second_out(l2),
    .digital_line_second_oe_n_out(l2_oe_n));
  task automatic end_of_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    chk(d, exp, $sformatf("reg %h", a));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // one-cycle pulse of the transfer end or the sample tick
  task automatic pulse(input logic x, input logic [3:0] e);
    cyc(1);
    xfer_end = x;
    tick = ~x;
    edges = e;
    cyc(1);
    {xfer_end, tick, edges} = 6'h00;
  endtask
  task automatic t_ident();
    rdc(ADDR_MISC, MISC_RESET);
    chk({15'h0, l1_oe_n}, 16'h0000, "first line driven");
    rdc(ADDR_PRODUCT, 16'h5a5a);
    rdc(ADDR_LOT_FIRST, 16'h1111);
    rdc(ADDR_LOT_SECOND, 16'h2222);
    rdc(ADDR_UNIT, 16'h0005);
    rdc(ADDR_SLEEP, 16'h0000);
    $display("test ident done");
  endtask
  task automatic t_misc();
    host.wr(7'h34, 8'hff);
    host.wr(7'h35, 8'h01);
    rdc(ADDR_MISC, 16'h01c7);
    chk({13'h0, stim, acc, perc}, 16'h0007, "stim comp perc");
    chk({14'h0, l1_oe_n, l2_oe_n}, 16'h0002, "second line");
    host.wr(7'h34, 8'h06);
    host.wr(7'h35, 8'h00);
    cyc(1);
    chk({13'h0, stim, acc, perc}, 16'h0000, "controls off");
    $display("test misc done");
  endtask
  task automatic t_flash();
    ck_bad = 1'b1;
    host.rd(7'h00, cnt);
    host.wr(ADDR_GLOBAL, 8'h08);
    rdc(ADDR_GLOBAL, 16'h0008);
    cyc(60);
    rdc(ADDR_GLOBAL, 16'h0000);
    rdc(7'h00, cnt + 16'h0001);
    host.wr(ADDR_GLOBAL, 8'h02);
    cyc(80);
    rdc(ADDR_GLOBAL, 16'h0000);
    rdc(7'h00, cnt + 16'h0002);
    host.wr(7'h3f, 8'hff);
    host.wr(ADDR_GLOBAL, 8'h04);
    cyc(5);
    rdc(ADDR_GLOBAL, 16'h0000);
    $display("test flash done");
  endtask
  task automatic t_diag();
    rdc(ADDR_DIAG, 16'h0004);
    pulse(1'b1, 4'h0);
    rdc(ADDR_DIAG, 16'h0000);
    pulse(1'b1, 4'h5);
    rdc(ADDR_DIAG, 16'h0008);
    rdc(ADDR_DIAG, 16'h0000);
    alarm1 = 1'b1;
    pulse(1'b0, 4'h0);
    rdc(ADDR_DIAG, 16'h0310);
    rdc(ADDR_DIAG, 16'h0000);
    pulse(1'b0, 4'h0);
    alarm1 = 1'b0;
    rdc(ADDR_DIAG, 16'h0310);
    sup_low = 1'b1;
    cyc(4);
    rdc(ADDR_DIAG, 16'h0001);
    sup_low = 1'b0;
    cyc(4);
    rdc(ADDR_DIAG, 16'h0000);
    $display("test diag done");
  endtask
  task automatic t_tests();
    host.wr(7'h35, 8'h08);
    rdc(ADDR_MISC, 16'h0806);
    cyc(50);
    rdc(ADDR_MISC, MISC_RESET);
    rdc(ADDR_DIAG, 16'h0040);
    ck_bad = 1'b0;
    st_fail = 6'h29;
    host.wr(7'h35, 8'h04);
    cyc(1010);
    rdc(ADDR_MISC, MISC_RESET);
    rdc(ADDR_DIAG, 16'ha420);
    st_fail = 6'h00;
    $display("test checksum selftest done");
  endtask
  task automatic t_sleep();
    host.wr(ADDR_SLEEP, 8'h02);
    cyc(5);
    chk({15'h0, sleeping}, 16'h0001, "timed asleep");
    cyc(30);
    chk({15'h0, sleeping}, 16'h0001, "still asleep");
    cyc(15);
    chk({15'h0, sleeping}, 16'h0000, "timed wake");
    host.wr(7'h3b, 8'h01);
    cyc(100);
    chk({15'h0, sleeping}, 16'h0001, "normal sleep");
    host.wake();
    cyc(2);
    chk({15'h0, sleeping}, 16'h0000, "select wake");
    host.wr(7'h3b, 8'h01);
    rp_n = 1'b0;
    cyc(6);
    chk({15'h0, sleeping}, 16'h0000, "pin wake");
    $display("test sleep done");
  endtask
  task automatic t_swreset();
    host.wr(7'h34, 8'h00);
    host.wr(ADDR_GLOBAL, 8'h80);
    cyc(2);
    chk({15'h0, halt}, 16'h0001, "halted");
    cyc(1010);
    rdc(ADDR_GLOBAL, 16'h0000);
    rdc(ADDR_MISC, MISC_RESET);
    $display("test swreset done");
  endtask
  // hang guard; the run needs under three thousand cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("mismatch at %0t: run timed out", $time);
      end_of_test();
    end
  end
  initial begin
    cyc(16);
    reset_in = 1'b0;
    cyc(2);
    t_ident();
    t_misc();
    t_flash();
    t_diag();
    t_tests();
    t_sleep();
    t_swreset();
    end_of_test();
  end
endmodule
